// file: design/cfg_pkg.sv
package cfg_pkg;
  localparam logic [9:0] port_index = 10'h3fa;
  localparam logic [9:0] port_data = 10'h2fa;
  localparam logic [7:0] unlock_first = 8'h55;
  localparam logic [7:0] unlock_second = 8'haa;
  localparam logic [3:0] idx_unit = 4'h0;
  localparam logic [3:0] idx_serial = 4'h1;
  localparam logic [3:0] idx_power = 4'h2;
  localparam logic [3:0] idx_exit = 4'hf;
  localparam logic [7:0] unit_reset = 8'h00;
  localparam logic [7:0] serial_reset = 8'h00;
  localparam logic [7:0] power_reset = 8'h7c;
  localparam int b_disk_en = 7;
  localparam int b_floppy_en = 6;
  localparam int b_mouse_en = 5;
  localparam int b_game_en = 4;
  localparam int b_disk_pri = 3;
  localparam int b_prn_normal = 2;
  localparam int b_valid = 7;
  localparam int b_pwr_mouse = 6;
  localparam int b_pwr_printer = 5;
  localparam int b_pwr_serial = 4;
  localparam int b_pwr_floppy = 3;
  localparam int b_pwr_disk = 2;
  localparam logic [9:0] game_addr = 10'h201;
  localparam logic [9:0] com_a_base = 10'h3f8;
  localparam logic [9:0] com_b_base = 10'h2f8;
  localparam logic [9:0] com_c_base = 10'h3e8;
  localparam logic [9:0] com_d_base = 10'h2e8;
  localparam logic [9:0] prn_a_base = 10'h3bc;
  localparam logic [9:0] prn_b_base = 10'h378;
  localparam logic [9:0] prn_c_base = 10'h278;
  localparam logic [9:0] disk_pri_cmd = 10'h1f0;
  localparam logic [9:0] disk_sec_cmd = 10'h170;
  localparam logic [9:0] disk_pri_ctl = 10'h3f6;
  localparam logic [9:0] disk_sec_ctl = 10'h376;
  localparam logic [9:0] fdc_pri_base = 10'h3f0;
  localparam logic [9:0] fdc_sec_base = 10'h370;
  typedef enum logic [1:0] {lock_idle, lock_half, cfg_open} lock_state_t;
endpackage

// file: design/cfg_wr_if.sv
`timescale 1ns/1ps
interface cfg_wr_if;
  logic wr;
  logic [3:0] index;
  logic [7:0] data;
  logic [7:0] unit_reg;
  logic [7:0] serial_reg;
  logic [7:0] power_reg;
  modport ctrl (output wr, output index, output data,
    input unit_reg, input serial_reg, input power_reg);
  modport regs (input wr, input index, input data,
    output unit_reg, output serial_reg, output power_reg);
endinterface

// file: design/cfg_regs.sv
`timescale 1ns/1ps
module cfg_regs
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic [7:0] strap_unit,
  input wire logic [2:0] strap_serial,
  cfg_wr_if.regs bus
);
  logic [7:0] next_unit;
  logic [7:0] next_serial;
  logic [7:0] next_power;
  logic [7:0] unit_q;
  logic [7:0] serial_q;
  logic [7:0] power_q;

  always_comb
  begin
    next_unit = unit_q;
    next_serial = serial_q;
    next_power = power_q;
    if (sys_rst)
    begin
      // R3 R4 strap capture
      next_unit = {strap_unit[7:6], 1'b0, strap_unit[4:0]};
      next_serial = {5'h00, strap_serial};
      next_power = power_reset;
    end
    else if (bus.wr)
    begin
      // R2 software loads
      case (bus.index)
        idx_unit: next_unit = bus.data;
        idx_serial: next_serial = bus.data;
        idx_power: next_power = bus.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      unit_q <= next_unit;
      serial_q <= next_serial;
      power_q <= next_power;
    end
  end

  assign bus.unit_reg = unit_q;
  assign bus.serial_reg = serial_q;
  assign bus.power_reg = power_q;
endmodule

// file: design/multi_io_config_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Four write-only configuration registers at indices 00, 01, 02, 0F.
// R2: Registers 00 and 01 load from straps or host; 02, 0F host only.
// R3: Reset means hardware mode sampling straps; afterwards software mode.
// R4: Straps load register 00 bits 7,6,4..0 and register 01 bits 2..0.
// R5: Serial select field maps both UARTs onto four fixed windows.
// R6: Parallel select 00 off, 01 3BC, 10 378, 11 278.
// R7: Register 00 bits 7..4 enable disk, floppy, mouse, game.
// R8: Bit 3 picks primary or secondary disk windows.
// R9: Bit 2 zero is extended printer mode, one is normal.
// R10: Write 55 to 2FA then AA to 3FA to unlock.
// R11: Unlocked: index to 3FA, then data to 2FA stores register.
// R12: Exit by index 0F plus data write, or AA to 3FA.
// R13: Register 02 bits 6..2 power units; zero powers down.
// R14: Register 02 bit 7 marks configuration valid.
// R15: Any write to register 0F leaves configuration mode.
// R16: Game port at 201; all decodes follow register settings.
// R17: Floppy strap at reset picks primary or secondary floppy window.
// R18: Second disk select active on selected control window.
// R19: Writes during DMA address enable are ignored, unlock stays idle.
// R20: Any other port write breaks unlock back to waiting; here only other writes to 3FA or 2FA break it.
module multi_io_config_decode
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic [9:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic io_write_n,
  input wire logic io_read_n,
  input wire logic dma_addr_enable,
  input wire logic disk_if_enable,
  input wire logic floppy_enable,
  input wire logic game_enable,
  input wire logic disk_window_primary,
  input wire logic printer_normal_mode,
  input wire logic printer_select_hi,
  input wire logic printer_select_lo,
  input wire logic serial_select_b2,
  input wire logic serial_select_b1,
  input wire logic serial_select_b0,
  input wire logic floppy_window_strap,
  output logic config_mode,
  output logic config_valid,
  output logic mouse_enable,
  output logic printer_extended,
  output logic mouse_power_on,
  output logic printer_power_on,
  output logic serial_power_on,
  output logic floppy_power_on,
  output logic disk_if_power_on,
  output logic serial_window_a,
  output logic serial_window_b,
  output logic serial_window_c,
  output logic serial_window_d,
  output logic uart1_select,
  output logic uart2_select,
  output logic printer_window_a,
  output logic printer_window_b,
  output logic printer_window_c,
  output logic printer_select,
  output logic floppy_select,
  output logic game_read_n,
  output logic game_write_n,
  output logic disk_cmd_select_n,
  output logic disk_ctrl_select_n
);
  import cfg_pkg::*;

  cfg_wr_if wbus ();

  lock_state_t state;
  lock_state_t next_state;
  logic [3:0] index_q;
  logic [3:0] next_index;
  logic floppy_sec;
  logic next_floppy_sec;
  logic wr_prev;
  logic write_pulse;

  function automatic logic in_window(input logic [9:0] a,
    input logic [9:0] base, input int span_bits);
    in_window = (a >> span_bits) == (base >> span_bits);
  endfunction

  cfg_regs regs_i (
    .clk(clk),
    .ce(ce),
    .sys_rst(sys_rst),
    .strap_unit({disk_if_enable, floppy_enable, 1'b0, game_enable,
      disk_window_primary, printer_normal_mode, printer_select_hi,
      printer_select_lo}),
    .strap_serial({serial_select_b2, serial_select_b1, serial_select_b0}),
    .bus(wbus.regs)
  );

  // Writes act once, on the first clock edge that samples the write strobe low
  assign write_pulse = !io_write_n && wr_prev;

  logic hit_index;
  logic hit_data;
  // R19 ignore during dma
  assign hit_index = write_pulse && !dma_addr_enable
    && host_addr == port_index;
  assign hit_data = write_pulse && !dma_addr_enable
    && host_addr == port_data;

  always_comb
  begin
    next_state = state;
    next_index = index_q;
    wbus.wr = 1'b0;
    wbus.index = index_q;
    wbus.data = host_wdata;
    case (state)
      lock_idle:
      begin
        // R10 first unlock write
        if (hit_data && host_wdata == unlock_first)
          next_state = lock_half;
      end
      lock_half:
      begin
        // R10 second unlock write
        if (hit_index && host_wdata == unlock_second)
          next_state = cfg_open;
        // R20 broken sequence
        else if (hit_index || hit_data)
          next_state = lock_idle;
      end
      cfg_open:
      begin
        if (hit_index)
        begin
          // R12 exit by AA
          if (host_wdata == unlock_second)
            next_state = lock_idle;
          else
            next_index = host_wdata[3:0];
        end
        else if (hit_data)
        begin
          // R11 indexed store
          wbus.wr = 1'b1;
          // R15 R12 exit register
          if (index_q == idx_exit)
            next_state = lock_idle;
        end
      end
      default: next_state = lock_idle;
    endcase
    if (sys_rst)
    begin
      next_state = lock_idle;
      next_index = 4'h0;
    end
  end

  // R17 floppy strap
  assign next_floppy_sec = sys_rst ? !floppy_window_strap : floppy_sec;

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      state <= next_state;
      index_q <= next_index;
      floppy_sec <= next_floppy_sec;
      wr_prev <= sys_rst ? 1'b1 : io_write_n;
    end
  end

  // R1 write-only, no read path
  logic [7:0] unit_r;
  logic [7:0] serial_r;
  logic [7:0] power_r;
  assign unit_r = wbus.unit_reg;
  assign serial_r = wbus.serial_reg;
  assign power_r = wbus.power_reg;

  // R3 software mode after reset
  assign config_mode = state == cfg_open;
  // R14 valid flag
  assign config_valid = power_r[b_valid];
  // R7 unit enables
  assign mouse_enable = unit_r[b_mouse_en];
  // R9 printer mode
  assign printer_extended = !unit_r[b_prn_normal];
  // R13 power controls
  assign mouse_power_on = power_r[b_pwr_mouse];
  assign printer_power_on = power_r[b_pwr_printer];
  assign serial_power_on = power_r[b_pwr_serial];
  assign floppy_power_on = power_r[b_pwr_floppy];
  assign disk_if_power_on = power_r[b_pwr_disk];

  logic [9:0] u1_base;
  logic [9:0] u2_base;
  logic u1_on;
  logic u2_on;
  // R5 serial map
  always_comb
  begin
    u1_on = 1'b1;
    u2_on = 1'b1;
    u1_base = com_a_base;
    u2_base = com_b_base;
    case (serial_r[2:0])
      3'h0:
      begin
        u1_on = 1'b0;
        u2_on = 1'b0;
      end
      3'h1: u2_on = 1'b0;
      3'h2: u1_on = 1'b0;
      3'h3: ;
      3'h4:
      begin
        u1_base = com_c_base;
        u2_base = com_d_base;
      end
      3'h5:
      begin
        u1_on = 1'b0;
        u2_base = com_a_base;
      end
      3'h6:
      begin
        u1_base = com_b_base;
        u2_on = 1'b0;
      end
      default:
      begin
        u1_base = com_b_base;
        u2_base = com_a_base;
      end
    endcase
  end

  logic access;
  assign access = (!io_read_n || !io_write_n) && !dma_addr_enable;

  // R16 unit decodes
  assign uart1_select = access && u1_on && serial_power_on
    && in_window(host_addr, u1_base, 3);
  assign uart2_select = access && u2_on && serial_power_on
    && in_window(host_addr, u2_base, 3);
  assign serial_window_a = (u1_on && u1_base == com_a_base)
    || (u2_on && u2_base == com_a_base);
  assign serial_window_b = (u1_on && u1_base == com_b_base)
    || (u2_on && u2_base == com_b_base);
  assign serial_window_c = u1_on && u1_base == com_c_base;
  assign serial_window_d = u2_on && u2_base == com_d_base;

  // R6 parallel select
  assign printer_window_a = unit_r[1:0] == 2'h1;
  assign printer_window_b = unit_r[1:0] == 2'h2;
  assign printer_window_c = unit_r[1:0] == 2'h3;
  assign printer_select = access && printer_power_on && (
    (printer_window_a && in_window(host_addr, prn_a_base, 2)) ||
    (printer_window_b && in_window(host_addr, prn_b_base, 2)) ||
    (printer_window_c && in_window(host_addr, prn_c_base, 2)));

  assign floppy_select = access && unit_r[b_floppy_en] && floppy_power_on
    && in_window(host_addr, floppy_sec ? fdc_sec_base : fdc_pri_base, 3);

  logic game_hit;
  assign game_hit = unit_r[b_game_en] && !dma_addr_enable
    && host_addr == game_addr;
  assign game_read_n = !(game_hit && !io_read_n);
  assign game_write_n = !(game_hit && !io_write_n);

  logic disk_on;
  assign disk_on = access && unit_r[b_disk_en] && disk_if_power_on;
  // R8 disk window
  assign disk_cmd_select_n = !(disk_on && in_window(host_addr,
    unit_r[b_disk_pri] ? disk_pri_cmd : disk_sec_cmd, 3));
  // R18 control window
  assign disk_ctrl_select_n = !(disk_on && in_window(host_addr,
    unit_r[b_disk_pri] ? disk_pri_ctl : disk_sec_ctl, 1));
endmodule

// file: test/host_bus.sv
`timescale 1ns/1ps
module host_bus (
  input wire logic clk,
  output logic [9:0] addr,
  output logic [7:0] wdata,
  output logic wr_n,
  output logic rd_n,
  output logic dma
);
  event snap;
  initial
  begin
    addr = 10'h000;
    wdata = 8'h00;
    wr_n = 1'b1;
    rd_n = 1'b1;
    dma = 1'b0;
  end
  task automatic cyc(input logic [9:0] a, input logic [7:0] d,
    input logic w, input logic m);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    dma <= m;
    wr_n <= !w;
    rd_n <= w;
    @(posedge clk);
    -> snap;
    @(posedge clk);
    // Released data no longer shows the written byte
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    wdata <= ~d;
    dma <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// file: test/multi_io_config_decode_props.sv
`timescale 1ns/1ps
module multi_io_config_decode_props
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic [9:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic io_write_n,
  input wire logic io_read_n,
  input wire logic dma_addr_enable,
  input wire logic config_mode,
  input wire logic config_valid,
  input wire logic mouse_power_on,
  input wire logic disk_if_power_on,
  input wire logic printer_window_a,
  input wire logic printer_window_b,
  input wire logic printer_window_c,
  input wire logic game_read_n,
  input wire logic disk_cmd_select_n,
  input wire logic disk_ctrl_select_n
);
  logic prev_wr_n;
  logic take;
  // A write counts once, on the edge the strobe first reads low
  assign take = ce && !io_write_n && prev_wr_n && !dma_addr_enable;
  always_ff @(posedge clk)
    if (ce)
      prev_wr_n <= io_write_n;
  default clocking ck @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_mode;
    !$stable(config_mode) |-> $past(take);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved alone");
  property p_unlock;
    $rose(config_mode) |-> $past(host_addr) == port_index
      && $past(host_wdata) == unlock_second;
  endproperty
  a_unlock: assert property (p_unlock) else $error("bad unlock");
  property p_exit;
    $fell(config_mode) |-> $past(host_addr) == port_data
      || $past(host_wdata) == unlock_second;
  endproperty
  a_exit: assert property (p_exit) else $error("bad exit");
  property p_pwr;
    !$stable({config_valid, mouse_power_on, disk_if_power_on})
      |-> $past(take && config_mode && host_addr == port_data);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power moved alone");
  property p_game;
    !game_read_n |-> host_addr == game_addr && !io_read_n
      && !dma_addr_enable;
  endproperty
  a_game: assert property (p_game) else $error("game decode");
  property p_cmd;
    !disk_cmd_select_n |-> host_addr[9:3] == disk_pri_cmd[9:3]
      || host_addr[9:3] == disk_sec_cmd[9:3];
  endproperty
  a_cmd: assert property (p_cmd) else $error("disk cmd decode");
  property p_ctl;
    !disk_ctrl_select_n |-> host_addr[9:1] == disk_pri_ctl[9:1]
      || host_addr[9:1] == disk_sec_ctl[9:1];
  endproperty
  a_ctl: assert property (p_ctl) else $error("disk ctl decode");
  property p_prn;
    $onehot0({printer_window_a, printer_window_b, printer_window_c});
  endproperty
  a_prn: assert property (p_prn) else $error("printer windows");
  c_unlock: cover property ($rose(config_mode));
  c_game: cover property (!game_read_n);
  c_ctl: cover property (!disk_ctrl_select_n);
endmodule
bind multi_io_config_decode multi_io_config_decode_props chk (.clk, .ce,
  .sys_rst, .host_addr, .host_wdata, .io_write_n, .io_read_n,
  .dma_addr_enable, .config_mode, .config_valid, .mouse_power_on,
  .disk_if_power_on, .printer_window_a, .printer_window_b,
  .printer_window_c, .game_read_n, .disk_cmd_select_n, .disk_ctrl_select_n);

// file: test/multi_io_config_decode_tb.sv
`timescale 1ns/1ps
module multi_io_config_decode_tb;
  import cfg_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [10:0] st = 11'h000;
  logic [9:0] a;
  logic [7:0] d;
  logic wr_n;
  logic rd_n;
  logic dma;
  wire [23:0] g;
  logic [7:0] u;
  logic [7:0] s;
  logic [7:0] p;
  logic [3:0] ix;
  logic md;
  logic hf;
  logic fs;
  int failures = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  logic [47:0] q[$];
  always #2 clk = ~clk;
  host_bus host (.clk(clk), .addr(a), .wdata(d), .wr_n(wr_n), .rd_n(rd_n),
    .dma(dma));
  multi_io_config_decode dut (.clk(clk), .ce(1'b1), .sys_rst(sys_rst),
    .host_addr(a), .host_wdata(d), .io_write_n(wr_n), .io_read_n(rd_n),
    .dma_addr_enable(dma), .disk_if_enable(st[6]), .floppy_enable(st[5]),
    .game_enable(st[4]), .disk_window_primary(st[3]),
    .printer_normal_mode(st[2]), .printer_select_hi(st[1]),
    .printer_select_lo(st[0]), .serial_select_b2(st[9]),
    .serial_select_b1(st[8]), .serial_select_b0(st[7]),
    .floppy_window_strap(st[10]), .config_mode(g[18]),
    .config_valid(g[17]), .mouse_enable(g[16]), .printer_extended(g[15]),
    .mouse_power_on(g[14]), .printer_power_on(g[13]),
    .serial_power_on(g[12]), .floppy_power_on(g[11]),
    .disk_if_power_on(g[10]), .serial_window_a(g[9]),
    .serial_window_b(g[8]), .serial_window_c(g[7]), .serial_window_d(g[6]),
    .uart1_select(g[23]), .uart2_select(g[22]), .printer_window_a(g[5]),
    .printer_window_b(g[4]), .printer_window_c(g[3]),
    .printer_select(g[21]),
    .floppy_select(g[19]), .game_read_n(g[2]), .game_write_n(g[20]),
    .disk_cmd_select_n(g[1]), .disk_ctrl_select_n(g[0]));
  // Mask drops serial and printer window flags and disk selects while those units are powered down
  function automatic logic [47:0] note(input logic [9:0] x, input logic wt,
    input logic rd);
    logic [9:0] cb;
    logic [9:0] kb;
    logic [9:0] fb;
    logic [3:0] hw;
    logic [2:0] sl;
    logic ac;
    logic u1;
    logic u2;
    logic pr;
    cb = u[3] ? disk_pri_cmd : disk_sec_cmd;
    kb = u[3] ? disk_pri_ctl : disk_sec_ctl;
    fb = fs ? fdc_sec_base : fdc_pri_base;
    sl = s[2:0];
    ac = wt || rd;
    // Address inside the 3F8, 2F8, 3E8, 2E8 serial windows
    hw = {x[9:3] == com_a_base[9:3], x[9:3] == com_b_base[9:3],
      x[9:3] == com_c_base[9:3], x[9:3] == com_d_base[9:3]};
    u1 = (sl == 3'h1 || sl == 3'h3) && hw[3] || sl == 3'h4 && hw[1]
      || (sl == 3'h6 || sl == 3'h7) && hw[2];
    u2 = (sl == 3'h2 || sl == 3'h3) && hw[2] || sl == 3'h4 && hw[0]
      || (sl == 3'h5 || sl == 3'h7) && hw[3];
    pr = u[1:0] == 2'h1 && x[9:2] == prn_a_base[9:2]
      || u[1:0] == 2'h2 && x[9:2] == prn_b_base[9:2]
      || u[1:0] == 2'h3 && x[9:2] == prn_c_base[9:2];
    return {5'h1f, 9'h1ff, {4{p[4]}}, {3{p[5]}}, 1'b1, {2{p[2]}},
      ac && p[4] && u1, ac && p[4] && u2, ac && p[5] && pr,
      !(wt && u[4] && x == game_addr),
      ac && u[6] && p[3] && x[9:3] == fb[9:3],
      md, p[7], u[5], !u[2], p[6:2], s[0], s[1], {2{s[2:0] == 3'h4}},
      u[1:0] == 2'h1, u[1:0] == 2'h2, u[1:0] == 2'h3,
      !(rd && u[4] && x == game_addr), !(ac && u[7] && x[9:3] == cb[9:3]),
      !(ac && u[7] && x[9:1] == kb[9:1])};
  endfunction
  task automatic op(input logic [9:0] x, input logic [7:0] y,
    input logic w, input logic m);
    // Only writes to the two ports move the unlock sequence
    if (w && !m && (x == port_index || x == port_data))
    begin
      if (!md)
      begin
        md = hf && x == port_index && y == unlock_second;
        hf = !hf && x == port_data && y == unlock_first;
      end
      else if (x == port_index)
      begin
        md = y != unlock_second;
        if (md)
          ix = y[3:0];
      end
      else
        case (ix)
          idx_unit: u = y;
          idx_serial: s = y;
          idx_power: p = y;
          idx_exit: md = 1'b0;
          default: ;
        endcase
    end
    q.push_back(note(x, w && !m, !w && !m));
    host.cyc(x, y, w, m);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] y);
    op(port_index, {4'h0, i}, 1'b1, 1'b0);
    op(port_data, y, 1'b1, 1'b0);
  endtask
  task automatic unl;
    op(port_data, unlock_first, 1'b1, 1'b0);
    op(port_index, unlock_second, 1'b1, 1'b0);
  endtask
  task automatic rst(input int n);
    @(posedge clk);
    sys_rst <= 1'b1;
    st <= 11'($urandom);
    repeat (n) @(posedge clk);
    sys_rst <= 1'b0;
    u = {st[6:5], 1'b0, st[4:0]};
    s = {5'h00, st[9:7]};
    p = power_reset;
    md = 1'b0;
    hf = 1'b0;
    ix = idx_unit;
    fs = !st[10];
    @(posedge clk);
    // Straps moving after release must not reach the registers
    st <= ~st;
    op(10'h000, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [47:0] n);
    cmp_count++;
    if ((g & n[47:24]) !== (n[23:0] & n[47:24]))
    begin
      failures++;
      $display("[ERR] %0t outputs %h expected %h", $time, g, n[23:0]);
    end
  endtask
  always @(host.snap)
  begin
    #1;
    chk(q.pop_front());
  end
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 4000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(32'hf5f93887));
    rst(6);
    wr(idx_power, 8'h00);
    op(port_data, unlock_first, 1'b1, 1'b0);
    op(port_data, 8'h12, 1'b1, 1'b0);
    op(port_index, unlock_second, 1'b1, 1'b0);
    op(port_data, unlock_first, 1'b1, 1'b1);
    op(port_index, unlock_second, 1'b1, 1'b0);
    unl;
    for (int i = 0; i < 8; i++)
    begin
      wr(idx_serial, {5'($urandom), 3'(i)});
      wr(idx_unit, {6'($urandom), 2'(i)});
      wr(idx_power, 8'($urandom) | 8'(i << 2));
      wr(4'h3, 8'hff);
      op(game_addr, 8'h00, 1'b0, 1'b0);
      op(game_addr, 8'h00, 1'b0, 1'b1);
      op(game_addr, 8'h00, 1'b1, 1'b0);
      op(prn_a_base, 8'h00, 1'b0, 1'b0);
      op(prn_c_base + 10'(i & 3), 8'h00, 1'b0, 1'b0);
      op(disk_pri_cmd + 10'(i), 8'h00, 1'b0, 1'b0);
      op(disk_sec_cmd + 10'(i + 4), 8'h00, 1'b0, 1'b0);
      op(disk_pri_ctl + 10'(i), 8'h00, 1'b0, 1'b0);
      op(disk_sec_ctl + 10'(i & 1), 8'h00, 1'b0, 1'b0);
    end
    wr(idx_exit, 8'($urandom));
    wr(idx_power, 8'h00);
    unl;
    op(port_index, unlock_second, 1'b1, 1'b0);
    rst(3);
    summarize();
  end
endmodule
